// ---- shared/sio_pkg.sv ----
// Purpose: Shared constants and types for the synchronous serial receive / duplex block
// Assumes: Byte-wide shared word buffer of eight entries
// Notes: Serial clock rate selection lives outside this block; half period is a parameter
package sio_pkg;
   localparam int BUF_DEPTH = 8;
   localparam int IDX_W = 3;
   localparam logic [3:0] BITS_WIDE = 4'h8;
   localparam logic [3:0] BITS_NARROW = 4'h4;
   localparam logic [7:0] SCK_HALF_CYC_DEF = 8'h04;
   localparam logic [7:0] WORD_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_LOW     = 3'b001,
      ST_HIGH    = 3'b010,
      ST_WAIT_RX = 3'b011,
      ST_WAIT_TX = 3'b100,
      ST_EXT     = 3'b101
   } sio_state_e;
endpackage

// ---- hw/sync_bits.sv ----
// Purpose: Two flip-flop synchroniser for levels and toggles
// Assumes: Each bit crosses on its own; multi-bit use only for independent bits
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
module sync_bits #(
   parameter int W = 1
) (
   input wire logic clk_in,            // Destination clock
   input wire logic rstn_in,           // Async reset, active low
   input wire logic [W-1:0] d_in,      // Foreign-domain level
   output logic [W-1:0] q_out          // Synchronised level
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_r <= '0;
         q_out <= '0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // sync_bits

// ---- hw/ext_link_shifter.sv ----
// Purpose: Shift engine clocked by the peer's serial clock
// Assumes: Peer clock idles high; falling edge leads, rising edge trails
// Notes: The clock may stand still between words; the core ends frames on its own
`timescale 1ns/1ns
module ext_link_shifter
   import sio_pkg::*;
(
   input wire logic link_clk_in,        // Serial clock from the peer
   input wire logic rstn_in,            // Async reset, active low
   input wire logic run_in,             // Core-domain run level
   input wire logic narrow_in,          // 4-bit words, static while running
   input wire logic [7:0] tx_word_in,   // Next transmit word, stable per word
   input wire logic si_in,              // Serial data in
   output logic so_out,                 // Serial data out
   output logic [7:0] rx_word_out,      // Last completed word
   output logic done_tgl_out            // Flips once per completed word
);
   typedef struct packed {
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] word;
      logic tgl;
   } link_s;

   link_s s_r, s_nxt;
   logic run_s;
   logic [7:0] tx_hold_r;
   logic [3:0] nbits;

   sync_bits #(.W(1)) u_run_sync (
      .clk_in(link_clk_in),
      .rstn_in(rstn_in),
      .d_in(run_in),
      .q_out(run_s)
   );

   assign nbits = narrow_in ? BITS_NARROW : BITS_WIDE;

   always_comb begin
      s_nxt = s_r;
      if (!run_s) begin
         s_nxt.cnt = 4'h0;
      end else begin
         // Trailing edge samples input, LSB first [RULE11] [RULE21] [RULE22]
         s_nxt.shreg = narrow_in ? {4'h0, si_in, s_r.shreg[3:1]} : {si_in, s_r.shreg[7:1]};
         s_nxt.cnt = 4'(s_r.cnt + 4'h1);
         if (s_nxt.cnt == nbits) begin
            s_nxt.word = s_nxt.shreg;
            s_nxt.tgl = ~s_r.tgl;
            s_nxt.cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Leading edge drives output; word latched at its first bit [RULE11] [RULE22]
   always_ff @(negedge link_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_hold_r <= WORD_RESET;
         so_out <= 1'b1;
      end else if (s_r.cnt == 4'h0) begin
         tx_hold_r <= tx_word_in;
         so_out <= tx_word_in[0];
      end else begin
         so_out <= tx_hold_r[s_r.cnt[2:0]];
      end
   end

   assign rx_word_out = s_r.word;
   assign done_tgl_out = s_r.tgl;
endmodule // ext_link_shifter

// ---- hw/sio_core.sv ----
// Purpose: Receive and 8-bit transmit/receive engine of a clocked serial interface
// Assumes: Control inputs are core-clock levels; buffer access is one strobe per cycle
// Notes: Internal clock derived from core_clk_in; external clock has its own domain
// Overview of operation
// [RULE1] Internal-clock receive: unread previous word halts the clock until it is read.
// [RULE2] Receive: no wait once software has read any received word.
// [RULE3] Reading any buffer word, used or not, releases the receive wait.
// [RULE4] External-clock receive: unread previous word drops the new word and aborts.
// [RULE5] Software ends reception by clearing start or setting abort after the irq.
// [RULE6] Start cleared: finish current word, store it, stop, clear active flag.
// [RULE7] Software waits for active flag clear, then reads the last word.
// [RULE8] Abort stops reception at once, clears active flag, drops partial data.
// [RULE9] Internal clock: word count changed in the wait, before reading words.
// [RULE10] Software selects mode, writes transmit words, then sets start.
// [RULE11] Duplex: output driven on leading edges, input sampled on trailing edges.
// [RULE12] Duplex: each 8-bit word goes to the buffer; irq after the word count.
// [RULE13] Software reads all received words before writing new transmit words.
// [RULE14] Internal-clock duplex: clock halts until words are exchanged by software.
// [RULE15] Duplex: no wait once one new transmit word has been written.
// [RULE16] External-clock duplex: software services buffer before the next shift.
// [RULE17] Duplex start cleared: store current word, finish it, clear active flag (code finishes the word, then stores it).
// [RULE18] Duplex abort ends the exchange at once and clears the active flag.
// [RULE19] Internal-clock duplex: word count changed in the wait before buffer access.
// [RULE20] Word count is one to eight words of 4 or 8 bits.
// [RULE21] Words shift LSB first; 4-bit words store zero in the upper nibble.
// [RULE22] Leading edge is the falling clock edge, trailing edge the rising edge.
// [RULE23] Active flag is one from start until either ending method completes.
`timescale 1ns/1ns
module sio_core
   import sio_pkg::*;
#(
   parameter logic [7:0] SCK_HALF_CYC = SCK_HALF_CYC_DEF
) (
   input wire logic core_clk_in,              // Core clock, 10 MHz
   input wire logic rstn_in,                  // Async reset, active low
   input wire logic link_clk_in,              // Peer serial clock, external mode
   input wire logic mode_duplex_in,           // 0 receive, 1 8-bit transmit/receive
   input wire logic ext_clk_sel_in,           // 1 serial clock from the peer
   input wire logic narrow_in,                // 1 selects 4-bit words
   input wire logic [2:0] word_count_in,      // Words per group minus one
   input wire logic transfer_start_bit_in,    // Start control bit
   input wire logic transfer_abort_bit_in,    // Inhibit control bit
   input wire logic buf_wr_in,                // Buffer write strobe
   input wire logic buf_rd_in,                // Buffer read strobe
   input wire logic [2:0] buf_addr_in,        // Buffer word index
   input wire logic [7:0] buf_wdata_in,       // Buffer write data
   output logic [7:0] buf_rdata_out,          // Buffer read data, next cycle
   output logic transfer_active_flag_out,     // Operating-status flag
   output logic shift_busy_out,               // Shift in progress
   output logic serial_done_irq_out,          // One-cycle pulse per finished group
   output logic sck_out,                      // Serial clock drive
   output logic sck_oe_out,                   // Serial clock drive enable
   output logic so_out,                       // Serial data out
   input wire logic si_in                     // Serial data in
);
   typedef struct packed {
      sio_state_e st;
      logic [IDX_W-1:0] widx;
      logic [IDX_W-1:0] wlast;
      logic [3:0] bit_cnt;
      logic [7:0] div;
      logic [7:0] shreg;
      logic grp_pend;
      logic touched;
      logic active;
      logic start_d;
      logic irq;
      logic so;
      logic sck;
      logic [7:0] rdata;
      logic [7:0] tx_next;
      logic tgl_d;
      logic ext_run;
   } core_s;

   core_s s_r, s_nxt;
   logic [7:0] mem_r [BUF_DEPTH];
   logic si_s;
   logic tgl_s;
   logic ext_so;
   logic ext_tgl;
   logic [7:0] ext_word;
   logic [3:0] nbits;
   logic hw_we;
   logic [IDX_W-1:0] hw_addr;
   logic [7:0] hw_data;

   sync_bits #(.W(2)) u_in_sync (
      .clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .d_in({si_in, ext_tgl}),
      .q_out({si_s, tgl_s})
   );

   ext_link_shifter u_ext (
      .link_clk_in(link_clk_in),
      .rstn_in(rstn_in),
      .run_in(s_r.ext_run),
      .narrow_in(narrow_in),
      .tx_word_in(s_r.tx_next),
      .si_in(si_in),
      .so_out(ext_so),
      .rx_word_out(ext_word),
      .done_tgl_out(ext_tgl)
   );

   assign nbits = narrow_in ? BITS_NARROW : BITS_WIDE;

   always_comb begin
      logic [7:0] word;
      logic [IDX_W-1:0] nidx;
      logic grp_end;
      word = WORD_RESET;
      nidx = '0;
      grp_end = 1'b0;
      s_nxt = s_r;
      s_nxt.start_d = transfer_start_bit_in;
      s_nxt.irq = 1'b0;
      s_nxt.tgl_d = tgl_s;
      hw_we = 1'b0;
      hw_addr = s_r.widx;
      hw_data = WORD_RESET;
      if (buf_rd_in) begin
         s_nxt.rdata = mem_r[buf_addr_in];
      end
      unique case (s_r.st)
         ST_IDLE: begin
            s_nxt.sck = 1'b1;
            if (transfer_start_bit_in && !s_r.start_d && !transfer_abort_bit_in) begin
               s_nxt.active = 1'b1;                                    // [RULE23]
               s_nxt.widx = '0;
               s_nxt.wlast = word_count_in;                            // [RULE20]
               s_nxt.grp_pend = 1'b0;
               s_nxt.touched = 1'b0;
               s_nxt.bit_cnt = 4'h0;
               s_nxt.div = 8'h00;
               s_nxt.shreg = mode_duplex_in ? mem_r[0] : WORD_RESET;
               if (ext_clk_sel_in) begin
                  s_nxt.ext_run = 1'b1;
                  s_nxt.st = ST_EXT;
               end else begin
                  s_nxt.so = mem_r[0][0] & mode_duplex_in;
                  s_nxt.sck = 1'b0;
                  s_nxt.st = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            s_nxt.div = 8'(s_r.div + 8'h01);
            if (s_nxt.div == SCK_HALF_CYC) begin
               s_nxt.div = 8'h00;
               s_nxt.sck = 1'b1;                                       // [RULE22]
               // Rising edge samples, LSB first [RULE11] [RULE21]
               s_nxt.shreg = narrow_in ? {4'h0, si_s, s_r.shreg[3:1]} : {si_s, s_r.shreg[7:1]};
               s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
               s_nxt.st = ST_HIGH;
            end
         end
         ST_HIGH: begin
            s_nxt.div = 8'(s_r.div + 8'h01);
            if (s_nxt.div == SCK_HALF_CYC) begin
               s_nxt.div = 8'h00;
               if (s_r.bit_cnt != nbits) begin
                  s_nxt.so = s_r.shreg[0];                             // [RULE11]
                  s_nxt.sck = 1'b0;
                  s_nxt.st = ST_LOW;
               end else if (!mode_duplex_in && s_r.grp_pend && s_r.widx == '0 && !s_r.touched) begin
                  s_nxt.st = ST_WAIT_RX;                               // [RULE1] [RULE2]
               end else begin
                  word = s_r.shreg;
                  hw_we = 1'b1;                                        // [RULE12]
               end
            end
         end
         ST_WAIT_RX: begin
            s_nxt.wlast = word_count_in;                               // [RULE9]
            if (!transfer_start_bit_in || s_r.touched) begin
               word = s_r.shreg;
               hw_we = 1'b1;                                           // [RULE3] [RULE6]
            end
         end
         ST_WAIT_TX: begin
            s_nxt.wlast = word_count_in;                               // [RULE19]
            if (!transfer_start_bit_in) begin
               s_nxt.active = 1'b0;                                    // [RULE17]
               s_nxt.st = ST_IDLE;
            end else if (s_r.touched) begin
               s_nxt.grp_pend = 1'b0;                                  // [RULE14] [RULE15]
               s_nxt.shreg = mem_r[0];
               s_nxt.so = mem_r[0][0];
               s_nxt.bit_cnt = 4'h0;
               s_nxt.sck = 1'b0;
               s_nxt.st = ST_LOW;
            end
         end
         ST_EXT: begin
            // Word from the link domain is held stable until the next toggle
            s_nxt.tx_next = mode_duplex_in ? mem_r[s_r.widx] : WORD_RESET;
            if (tgl_s != s_r.tgl_d) begin
               if (!mode_duplex_in && s_r.grp_pend && s_r.widx == '0 && !s_r.touched) begin
                  s_nxt.active = 1'b0;                                 // [RULE4]
                  s_nxt.ext_run = 1'b0;
                  s_nxt.st = ST_IDLE;
               end else begin
                  word = ext_word;
                  hw_we = 1'b1;                                        // [RULE12]
               end
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
            s_nxt.active = 1'b0;
         end
      endcase

      // A stored word advances the index and may close a group
      if (hw_we) begin
         hw_data = narrow_in ? {4'h0, word[3:0]} : word;               // [RULE21]
         if (!mode_duplex_in && s_r.widx == '0) begin
            s_nxt.grp_pend = 1'b0;
         end
         grp_end = (s_r.widx == s_r.wlast);
         nidx = grp_end ? '0 : IDX_W'(s_r.widx + 1'b1);
         s_nxt.widx = nidx;
         s_nxt.bit_cnt = 4'h0;
         if (grp_end) begin
            s_nxt.irq = 1'b1;                                          // [RULE12]
            s_nxt.grp_pend = 1'b1;
            s_nxt.touched = 1'b0;
            s_nxt.wlast = word_count_in;
         end
         if (!transfer_start_bit_in) begin
            s_nxt.active = 1'b0;                                       // [RULE6] [RULE17]
            s_nxt.ext_run = 1'b0;
            s_nxt.sck = 1'b1;
            s_nxt.st = ST_IDLE;
         end else if (ext_clk_sel_in) begin
            s_nxt.st = ST_EXT;
         end else if (mode_duplex_in && grp_end) begin
            s_nxt.sck = 1'b1;
            s_nxt.st = ST_WAIT_TX;                                     // [RULE14]
         end else begin
            s_nxt.shreg = mode_duplex_in ? mem_r[nidx] : WORD_RESET;
            s_nxt.so = mem_r[nidx][0] & mode_duplex_in;
            s_nxt.sck = 1'b0;
            s_nxt.st = ST_LOW;
         end
      end

      // Software access releases a wait; set wins over the group-end clear
      if ((!mode_duplex_in && buf_rd_in) || (mode_duplex_in && buf_wr_in)) begin
         s_nxt.touched = 1'b1;                                         // [RULE2] [RULE3] [RULE15]
      end

      // Abort overrides state, flag, clock, store and irq, and drops the partial word
      if (transfer_abort_bit_in && s_r.active) begin
         s_nxt.active = 1'b0;                                          // [RULE8] [RULE18]
         s_nxt.ext_run = 1'b0;
         s_nxt.sck = 1'b1;
         s_nxt.st = ST_IDLE;
         hw_we = 1'b0;
         s_nxt.irq = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_r <= '{st: ST_IDLE, so: 1'b1, sck: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Hardware store wins over a software write to the same word
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < BUF_DEPTH; i++) begin
            mem_r[i] <= WORD_RESET;
         end
      end else if (hw_we) begin
         mem_r[hw_addr] <= hw_data;
         if (buf_wr_in && buf_addr_in != hw_addr) begin
            mem_r[buf_addr_in] <= buf_wdata_in;
         end
      end else if (buf_wr_in) begin
         mem_r[buf_addr_in] <= buf_wdata_in;
      end
   end

   assign buf_rdata_out = s_r.rdata;
   assign transfer_active_flag_out = s_r.active;                       // [RULE23]
   assign shift_busy_out = (s_r.st == ST_LOW) || (s_r.st == ST_HIGH) || (s_r.st == ST_EXT);
   assign serial_done_irq_out = s_r.irq;
   assign sck_out = s_r.sck;
   assign sck_oe_out = !ext_clk_sel_in;
   assign so_out = ext_clk_sel_in ? ext_so : s_r.so;
endmodule // sio_core

// ---- bench/sio_core_properties.sv ----
// Purpose: Timing checks on the serial block's control and clock ports
// Assumes: Single core clock domain; reset async, active low
// Notes: Half-period check counts core cycles with sck low
`timescale 1ns/1ns
module sio_core_checker
   import sio_pkg::*;
#(
   parameter logic [7:0] SCK_HALF_CYC = SCK_HALF_CYC_DEF
) (
   input wire logic core_clk_in, // Core clock
   input wire logic rstn_in, // Reset, active low
   input wire logic ext_clk_sel_in, // Peer clock select
   input wire logic transfer_start_bit_in, // Start bit
   input wire logic transfer_abort_bit_in, // Inhibit bit
   input wire logic transfer_active_flag_out, // Active flag
   input wire logic shift_busy_out, // Shifting
   input wire logic serial_done_irq_out, // Group done pulse
   input wire logic sck_out, // Serial clock drive
   input wire logic sck_oe_out // Serial clock enable
);
   logic [7:0] lo_cnt_r;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lo_cnt_r <= 8'h00;
      end else begin
         lo_cnt_r <= sck_out ? 8'h00 : lo_cnt_r + 8'h01;
      end
   end
   start_taken_a: assert property (
      $rose(transfer_start_bit_in) && !transfer_abort_bit_in && !transfer_active_flag_out
      |=> transfer_active_flag_out) else $error("start edge not taken");
   abort_stops_a: assert property (
      transfer_abort_bit_in |=> !transfer_active_flag_out) else $error("abort left flag set");
   stays_idle_a: assert property (
      !transfer_start_bit_in && !transfer_active_flag_out |=> !transfer_active_flag_out)
      else $error("flag rose without start");
   irq_pulse_a: assert property (
      serial_done_irq_out |=> !serial_done_irq_out) else $error("irq longer than one cycle");
   irq_active_a: assert property (
      serial_done_irq_out |-> $past(transfer_active_flag_out)) else $error("irq outside transfer");
   busy_active_a: assert property (
      shift_busy_out |-> transfer_active_flag_out) else $error("shifting while flag clear");
   sck_idle_a: assert property (
      !transfer_active_flag_out && !$past(transfer_active_flag_out) |-> sck_out)
      else $error("serial clock not idle high");
   sck_enable_a: assert property (
      sck_oe_out == !ext_clk_sel_in) else $error("clock enable wrong");
   half_period_a: assert property (
      $rose(sck_out) && transfer_active_flag_out && !$past(transfer_abort_bit_in) && !ext_clk_sel_in
      |-> lo_cnt_r == SCK_HALF_CYC) else $error("low phase length wrong");
endmodule // sio_core_checker
bind sio_core sio_core_checker #(.SCK_HALF_CYC(SCK_HALF_CYC)) sio_core_checker_inst (
   .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ext_clk_sel_in(ext_clk_sel_in),
   .transfer_start_bit_in(transfer_start_bit_in), .transfer_abort_bit_in(transfer_abort_bit_in),
   .transfer_active_flag_out(transfer_active_flag_out), .shift_busy_out(shift_busy_out),
   .serial_done_irq_out(serial_done_irq_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out)
);

// ---- bench/serial_peer.sv ----
// Purpose: Behavioural serial peer: sends a word, captures the returned word
// Assumes: Clock idles high; falling edge leads, rising edge trails
// Notes: Peer clock runs only inside bursts, 6 ns period
`timescale 1ns/1ns
module serial_peer (
   input wire logic sck_in, // Clock from the block
   input wire logic sck_oe_in, // Block drives the clock
   input wire logic narrow_in, // 4-bit words
   input wire logic so_in, // Data from the block
   input wire logic [7:0] tx_in, // Word to send
   output logic si_out, // Data to the block
   output logic link_clk_out, // Peer clock
   output logic [7:0] rx_out // Last captured word
);
   logic [7:0] sh;
   logic [7:0] rx_sh;
   logic [2:0] cnt;
   logic [2:0] rcnt;
   wire logic line = sck_oe_in ? sck_in : link_clk_out;
   initial begin
      si_out = 1'b1;
      link_clk_out = 1'b1;
      rx_out = 8'h00;
      arm();
   end
   task automatic arm();
      cnt = 3'h0;
      rcnt = 3'h0;
      sh = 8'h00;
      rx_sh = 8'h00;
   endtask
   // Priming pulses only fill the block's run synchroniser
   task automatic burst(input int prime, input int bits);
      repeat (prime) begin
         link_clk_out = 1'b0;
         #3 link_clk_out = 1'b1;
         #3;
      end
      arm();
      repeat (bits) begin
         link_clk_out = 1'b0;
         #3 link_clk_out = 1'b1;
         #3;
      end
   endtask
   always @(negedge line) begin
      si_out = (cnt == 3'h0) ? tx_in[0] : sh[0];
      sh = (cnt == 3'h0) ? tx_in >> 1 : sh >> 1;
      cnt = (cnt == (narrow_in ? 3'h3 : 3'h7)) ? 3'h0 : cnt + 3'h1;
   end
   always @(posedge line) begin
      rx_sh = {so_in, rx_sh[7:1]};
      if (rcnt == 3'h7) begin
         rx_out = rx_sh;
      end
      rcnt = rcnt + 3'h1;
   end
endmodule // serial_peer

// ---- bench/testbench.sv ----
// Purpose: Directed checks of receive and duplex transfers
// Assumes: Default half period of four core cycles
// Notes: Inputs change 1 ns after the rising core edge
`timescale 1ns/1ns
module testbench;
   logic clk, rstn, dup, ext, nar, start, abort, wr, rd, sck, sck_oe, so, si, lclk, act, busy, irq;
   logic [2:0] wc, addr;
   logic [7:0] wd, rdata, ptx, prx;
   int errors, compares;
   sio_core sio_core_inst (.core_clk_in(clk), .rstn_in(rstn), .link_clk_in(lclk), .mode_duplex_in(dup),
      .ext_clk_sel_in(ext), .narrow_in(nar), .word_count_in(wc), .transfer_start_bit_in(start),
      .transfer_abort_bit_in(abort), .buf_wr_in(wr), .buf_rd_in(rd), .buf_addr_in(addr),
      .buf_wdata_in(wd), .buf_rdata_out(rdata), .transfer_active_flag_out(act), .shift_busy_out(busy),
      .serial_done_irq_out(irq), .sck_out(sck), .sck_oe_out(sck_oe), .so_out(so), .si_in(si));
   serial_peer serial_peer_inst (.sck_in(sck), .sck_oe_in(sck_oe), .narrow_in(nar), .so_in(so),
      .tx_in(ptx), .si_out(si), .link_clk_out(lclk), .rx_out(prx));
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask
   // Trailing tick keeps strobes from being raised twice in one step
   task automatic bwr(input logic [2:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      tick();
      wr = 1'b0;
      tick();
   endtask
   task automatic brd(input logic [2:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      tick();
      rd = 1'b0;
      cmp8(rdata, exp);
      tick();
   endtask
   task automatic wait_irq(input int lim);
      for (int i = 0; i < lim && irq !== 1'b1; i++) tick();
      cmp1(irq, 1'b1);
   endtask
   task automatic wait_idle(input int lim);
      for (int i = 0; i < lim && act !== 1'b0; i++) tick();
      cmp1(act, 1'b0);
   endtask
   task automatic reset_values();
      cmp1(act, 1'b0);
      cmp1(sck, 1'b1);
      cmp1(so, 1'b1);
      cmp1(irq, 1'b0);
      cmp8(rdata, 8'h00);
   endtask
   task automatic rx_internal();
      ptx = 8'hb4;
      serial_peer_inst.arm();
      start = 1'b1;
      tick();
      cmp1(act, 1'b1);
      tick(10);
      ptx = 8'h3c;
      wait_irq(100);
      tick(120);
      cmp1(sck, 1'b1);
      wc = 3'h1;
      brd(3'h5, 8'h00);
      cmp1(irq, 1'b0);
      wc = 3'h0;
      ptx = 8'h5a;
      wait_irq(100);
      brd(3'h0, 8'h3c);
      wait_irq(100);
      start = 1'b0;
      wait_idle(100);
      brd(3'h0, 8'h5a);
   endtask
   task automatic abort_rx();
      start = 1'b1;
      tick(30);
      abort = 1'b1;
      tick(2);
      cmp1(act, 1'b0);
      brd(3'h0, 8'h5a);
      start = 1'b0;
      tick();
      start = 1'b1;
      tick(3);
      cmp1(act, 1'b0);
      abort = 1'b0;
      start = 1'b0;
      tick();
   endtask
   task automatic narrow_rx();
      nar = 1'b1;
      ptx = 8'hf9;
      serial_peer_inst.arm();
      tick();
      start = 1'b1;
      wait_irq(60);
      start = 1'b0;
      wait_idle(60);
      brd(3'h0, 8'h09);
      nar = 1'b0;
   endtask
   task automatic duplex();
      dup = 1'b1;
      wc = 3'h1;
      bwr(3'h0, 8'ha5);
      bwr(3'h1, 8'hc3);
      ptx = 8'h0f;
      serial_peer_inst.arm();
      start = 1'b1;
      tick(10);
      ptx = 8'he1;
      wait_irq(160);
      wc = 3'h0;
      cmp8(prx, 8'hc3);
      brd(3'h0, 8'h0f);
      brd(3'h1, 8'he1);
      tick(20);
      cmp1(sck, 1'b1);
      bwr(3'h0, 8'h66);
      start = 1'b0;
      wait_idle(100);
      cmp1(irq, 1'b1);
      cmp8(prx, 8'h66);
      dup = 1'b0;
      wc = 3'h0;
   endtask
   task automatic ext_rx();
      ext = 1'b1;
      ptx = 8'h96;
      tick();
      cmp1(sck_oe, 1'b0);
      start = 1'b1;
      tick(4);
      serial_peer_inst.burst(2, 8);
      wait_irq(10);
      ptx = 8'h11;
      serial_peer_inst.burst(0, 8);
      wait_idle(10);
      brd(3'h0, 8'h96);
      // Link side only sees the run level drop on its own clock
      serial_peer_inst.burst(3, 0);
      start = 1'b0;
      ext = 1'b0;
      tick();
   endtask
   task automatic ext_duplex();
      ext = 1'b1;
      dup = 1'b1;
      bwr(3'h0, 8'h3a);
      ptx = 8'hc5;
      start = 1'b1;
      tick(4);
      serial_peer_inst.burst(2, 8);
      wait_irq(10);
      cmp8(prx, 8'h3a);
      brd(3'h0, 8'hc5);
      bwr(3'h0, 8'h7e);
      start = 1'b0;
      serial_peer_inst.burst(0, 8);
      wait_idle(10);
      cmp8(prx, 8'h7e);
      {ext, dup} = 2'b00;
      tick();
   endtask
   task automatic finish_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rstn, dup, ext, nar, start, abort, wr, rd} = 8'h00;
      {wc, addr, wd, ptx} = 22'h000000;
      errors = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      reset_values();
      rx_internal();
      abort_rx();
      narrow_rx();
      duplex();
      ext_rx();
      ext_duplex();
      finish_test();
   end
   // Whole run needs well under 2000 core cycles
   initial begin
      #2000000;
      errors++;
      finish_test();
   end
endmodule // testbench
